/* vepfe_pkg_buf.sv */
/*
 * Shared constants and types of the video encoder pixel front end, plus
 * the two-entry stream buffer that sits between the 4:4:4 rebuild and
 * the twice-rate output stage.
 * Assumes one clock and an asynchronous active-low reset.
 */
package vepfe_pkg;
	localparam logic [10:0] CLKS_525   = 11'd1716;
	localparam logic [10:0] CLKS_625   = 11'd1728;
	localparam logic [9:0]  FLD0_525   = 10'd263;
	localparam logic [9:0]  FLD1_525   = 10'd262;
	localparam logic [9:0]  FLD0_625   = 10'd313;
	localparam logic [9:0]  FLD1_625   = 10'd312;
	localparam logic [31:0] SC_INC_525 = 32'h21f07c1f;
	localparam logic [31:0] SC_INC_625 = 32'h2a098acb;
	localparam logic [6:0]  RTC_BITS   = 7'd67;
	localparam int          RTC_SC_W   = 22;
	localparam logic [7:0]  CHROMA_MID = 8'h80;
	localparam logic [7:0]  TRC_FIRST  = 8'hff;
	localparam logic [7:0]  TRC_ZERO   = 8'h00;
	localparam int          TRC_H_BIT  = 4;
	localparam int          TRC_F_BIT  = 6;
	localparam logic [5:0]  ADDR_BASE  = 6'h2a; // arbitrary value
	localparam logic [1:0]  SCSEL_RESET = 2'b01;
	localparam logic [1:0]  SCSEL_LOCK  = 2'b10;
	localparam logic [1:0]  TMODE_0     = 2'd0;
	localparam logic [1:0]  TMODE_1     = 2'd1;
	localparam logic [1:0]  TMODE_2     = 2'd2;
	localparam logic [9:0]  COMP_MAX    = 10'h3ff;
	localparam logic [9:0]  CHROMA_OFS  = 10'h200;

	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} vepfe_pix_s;

	typedef enum logic [2:0] {
		I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_DATA, I2C_IGNORE
	} vepfe_i2c_e;

	// signed sine, 64 steps per turn, amplitude 127
	function automatic logic [7:0] vepfe_sine(input logic [5:0] ph);
		logic [3:0] idx;
		logic [7:0] mag;
		idx = ph[4] ? ~ph[3:0] : ph[3:0];
		case (idx)
			4'h0: mag = 8'h06;
			4'h1: mag = 8'h13;
			4'h2: mag = 8'h1f;
			4'h3: mag = 8'h2b;
			4'h4: mag = 8'h36;
			4'h5: mag = 8'h41;
			4'h6: mag = 8'h4c;
			4'h7: mag = 8'h55;
			4'h8: mag = 8'h5e;
			4'h9: mag = 8'h66;
			4'ha: mag = 8'h6d;
			4'hb: mag = 8'h73;
			4'hc: mag = 8'h78;
			4'hd: mag = 8'h7b;
			4'he: mag = 8'h7e;
			default: mag = 8'h7f;
		endcase
		vepfe_sine = ph[5] ? 8'(-mag) : mag;
	endfunction : vepfe_sine
endpackage : vepfe_pkg

`timescale 1ns/1ns
module vepfe_buf2 #(
	parameter int W = 24
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_valid,
	output logic              o_ready,
	input  wire logic [W-1:0] i_data,
	output logic              o_valid,
	input  wire logic         i_ready,
	output logic [W-1:0]      o_data
);
	logic [W-1:0] mem_reg [2];
	logic         wr_ptr_reg;
	logic         rd_ptr_reg;
	logic [1:0]   cnt_reg;
	logic         push;
	logic         pop;

	assign o_ready = (cnt_reg != 2'd2);
	assign o_valid = (cnt_reg != 2'd0);
	assign o_data  = mem_reg[rd_ptr_reg];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
		end else if (push) begin
			mem_reg[wr_ptr_reg] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			cnt_reg    <= 2'd0;
		end else begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
		end
	end
endmodule : vepfe_buf2

/* vepfe_top.sv */
/*
 * Pixel front end of a component-to-composite encoder: pixel port,
 * sync master/slave, subcarrier reset and line lock, 4:2:2 to 4:4:4,
 * twice-rate interpolation, quadrature modulation, host serial target.
 * Assumes all pins synchronous to I_CLK; the two-wire lines are
 * synchronised here. Mode bits arrive as ports, latched on I_MODE_LOAD.
 */
// Behaviour
// - narrow uses low eight lines, wide sixteen
// - line sync driven as master, sampled slave
// - field pin: field mode 1, vsync mode 2
// - blanking low means pixel bus ignored
// - reset-edge mode returns subcarrier to field zero
// - lock mode reads serial line-lock stream
// - reset gives 525, slave 0, narrow, dual
// - address low bit follows select pin
// - rebuild 4:2:2 into 4:4:4 samples
// - interpolate samples to twice pixel rate
// - modulate colour differences with synthesised subcarrier
// - composite and luma/chroma 10 bits, components 8
// - align timing to embedded reference codes, narrow bus only
// - master sync width and position programmable
// - square pixel only while timing slave
// - host configures via two-wire serial target
// - wide loads luma and chroma every second edge
// - subcarrier reset applied at next field start
`timescale 1ns/1ns
module vepfe_top (
	input  wire logic                I_CLK,
	input  wire logic                I_NRST,
	input  wire logic [15:0]         I_PIXEL_BUS,
	input  wire logic                I_BLANK_N,
	input  wire logic                I_LINE_SYNC_N,
	output logic                     O_LINE_SYNC_N,
	output logic                     O_LINE_SYNC_OE,
	input  wire logic                I_FIELD_VSYNC,
	output logic                     O_FIELD_VSYNC,
	output logic                     O_FIELD_VSYNC_OE,
	input  wire logic                I_SUBCARRIER_RESET_OR_LOCK_IN,
	input  wire logic                I_MODE_LOAD,
	input  wire logic                I_STD_625,
	input  wire logic                I_MASTER,
	input  wire logic [1:0]          I_TIMING_MODE,
	input  wire logic                I_WIDE_BUS,
	input  wire logic                I_SQUARE_PIXEL,
	input  wire logic                I_COMPONENT_OUT,
	input  wire logic                I_SUBCARRIER_PIN_SELECT_HI,
	input  wire logic                I_SUBCARRIER_PIN_SELECT_LO,
	input  wire logic [10:0]         I_HSYNC_START,
	input  wire logic [10:0]         I_HSYNC_WIDTH,
	input  wire logic [3:0]          I_VSYNC_LINES,
	output logic                     O_PIXEL_READY,
	input  wire logic                I_OUT_READY,
	output logic                     O_OUT_VALID,
	output logic [9:0]               O_COMPOSITE,
	output logic [9:0]               O_LUMA,
	output logic [9:0]               O_CHROMA,
	output vepfe_pkg::vepfe_pix_s    O_COMPONENT,
	output logic                     O_FIELD,
	output logic                     O_STD_625,
	output logic                     O_MASTER,
	output logic                     O_WIDE_BUS,
	output logic                     O_SQUARE_ACTIVE,
	input  wire logic                I_TARGET_ADDRESS_SELECT,
	input  wire logic                I_HOST_SERIAL_CLOCK,
	input  wire logic                I_HOST_SERIAL_DATA,
	output logic                     O_HOST_SERIAL_DATA,
	output logic                     O_HOST_SERIAL_DATA_OE,
	output logic [7:0]               O_HOST_BYTE,
	output logic                     O_HOST_BYTE_VALID,
	output logic                     O_HOST_BYTE_FIRST
);
	import vepfe_pkg::*;

	// mode registers
	logic       std625_reg, master_reg, wide_reg, sq_reg, comp_reg;
	logic [1:0] tmode_reg;
	logic       sq_active;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			std625_reg <= 1'b0;
			master_reg <= 1'b0;
			tmode_reg  <= TMODE_0;
			wide_reg   <= 1'b0;
			sq_reg     <= 1'b0;
			comp_reg   <= 1'b0;
		end else if (I_MODE_LOAD) begin
			std625_reg <= I_STD_625;
			master_reg <= I_MASTER;
			tmode_reg  <= I_TIMING_MODE;
			wide_reg   <= I_WIDE_BUS;
			sq_reg     <= I_SQUARE_PIXEL;
			comp_reg   <= I_COMPONENT_OUT;
		end
	end
	assign sq_active       = sq_reg & ~master_reg;
	assign O_STD_625       = std625_reg;
	assign O_MASTER        = master_reg;
	assign O_WIDE_BUS      = wide_reg;
	assign O_SQUARE_ACTIVE = sq_active;

	// pixel port: reference code detection and 4:2:2 unpacking
	logic [7:0] lo_byte, hi_byte, c_in;
	logic [1:0] trc_cnt_reg, ph_reg;
	logic       wslot_reg, wword_reg, trc_f_reg;
	logic       trc_xy, trc_eav, trc_fchg;
	logic       ev_cb, ev_y0, ev_cr, ev_y1;

	assign lo_byte  = I_PIXEL_BUS[7:0];
	assign hi_byte  = I_PIXEL_BUS[15:8];
	assign c_in     = wide_reg ? hi_byte : lo_byte;
	assign trc_xy   = I_BLANK_N & ~wide_reg & (trc_cnt_reg == 2'd3);
	assign trc_eav  = trc_xy & lo_byte[TRC_H_BIT];
	assign trc_fchg = trc_xy & (lo_byte[TRC_F_BIT] != trc_f_reg);

	always_comb begin
		ev_cb = 1'b0;
		ev_y0 = 1'b0;
		ev_cr = 1'b0;
		ev_y1 = 1'b0;
		if (I_BLANK_N) begin
			if (wide_reg) begin
				if (wslot_reg) begin
					ev_cb = ~wword_reg;
					ev_y0 = ~wword_reg;
					ev_cr = wword_reg;
					ev_y1 = wword_reg;
				end
			end else if (trc_cnt_reg == 2'd0 && lo_byte != TRC_FIRST) begin
				case (ph_reg)
					2'd0: ev_cb = 1'b1;
					2'd1: ev_y0 = 1'b1;
					2'd2: ev_cr = 1'b1;
					default: ev_y1 = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			trc_cnt_reg <= 2'd0;
			trc_f_reg   <= 1'b0;
			ph_reg      <= 2'd0;
			wslot_reg   <= 1'b0;
			wword_reg   <= 1'b0;
		end else begin
			wslot_reg <= wide_reg ? ~wslot_reg : 1'b0;
			if (ev_cr)
				wword_reg <= 1'b0;
			else if (ev_cb)
				wword_reg <= 1'b1;
			if (I_BLANK_N && !wide_reg) begin
				case (trc_cnt_reg)
					2'd0: trc_cnt_reg <= (lo_byte == TRC_FIRST) ? 2'd1 : 2'd0;
					2'd1: trc_cnt_reg <= (lo_byte == TRC_ZERO) ? 2'd2 : 2'd0;
					2'd2: trc_cnt_reg <= (lo_byte == TRC_ZERO) ? 2'd3 : 2'd0;
					default: trc_cnt_reg <= 2'd0;
				endcase
				if (trc_xy) begin
					trc_f_reg <= lo_byte[TRC_F_BIT];
					if (!lo_byte[TRC_H_BIT])
						ph_reg <= 2'd0;
				end else if (ev_cb | ev_y0 | ev_cr | ev_y1) begin
					ph_reg <= 2'(ph_reg + 2'd1);
				end
			end
		end
	end

	// 4:4:4 rebuild: odd luma takes the mean of neighbouring chroma
	logic [7:0] cb_n_reg, cr_n_reg, y0_n_reg, y1_n_reg;
	logic [7:0] cb_p_reg, cr_p_reg, y1_p_reg;
	logic       have_p_reg, emit0_reg, emit1;
	vepfe_pix_s push_pix, buf_pix;
	logic       push_valid, buf_valid, buf_pop;

	assign emit1 = ev_cr & have_p_reg;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cb_n_reg   <= CHROMA_MID;
			cr_n_reg   <= CHROMA_MID;
			y0_n_reg   <= 8'h00;
			y1_n_reg   <= 8'h00;
			cb_p_reg   <= CHROMA_MID;
			cr_p_reg   <= CHROMA_MID;
			y1_p_reg   <= 8'h00;
			have_p_reg <= 1'b0;
			emit0_reg  <= 1'b0;
		end else begin
			emit0_reg <= ev_cr;
			if (ev_cb) begin
				cb_p_reg <= cb_n_reg;
				cr_p_reg <= cr_n_reg;
				y1_p_reg <= y1_n_reg;
				cb_n_reg <= c_in;
			end
			if (ev_y0)
				y0_n_reg <= lo_byte;
			if (ev_y1)
				y1_n_reg <= lo_byte;
			if (ev_cr) begin
				cr_n_reg   <= c_in;
				have_p_reg <= 1'b1;
			end
		end
	end

	always_comb begin
		push_pix = '0;
		if (emit0_reg) begin
			push_pix.y  = y0_n_reg;
			push_pix.cb = cb_n_reg;
			push_pix.cr = cr_n_reg;
		end else begin
			push_pix.y  = y1_p_reg;
			push_pix.cb = 8'(({1'b0, cb_p_reg} + {1'b0, cb_n_reg}) >> 1);
			push_pix.cr = 8'(({1'b0, cr_p_reg} + {1'b0, c_in}) >> 1);
		end
	end
	assign push_valid = emit0_reg | emit1;

	vepfe_buf2 #(.W($bits(vepfe_pix_s))) u_buf (
		.i_clk   (I_CLK),
		.i_nrst  (I_NRST),
		.i_valid (push_valid),
		.o_ready (O_PIXEL_READY),
		.i_data  (push_pix),
		.o_valid (buf_valid),
		.i_ready (buf_pop),
		.o_data  (buf_pix)
	);

	// twice-rate stage: sample, midpoint, sample, ...
	vepfe_pix_s last_reg, sel_pix;
	logic       half_reg, produce;

	assign produce = I_OUT_READY & buf_valid;
	assign buf_pop = produce & ~half_reg;

	always_comb begin
		sel_pix = buf_pix;
		if (half_reg) begin
			sel_pix.y  = 8'(({1'b0, last_reg.y} + {1'b0, buf_pix.y}) >> 1);
			sel_pix.cb = 8'(({1'b0, last_reg.cb} + {1'b0, buf_pix.cb}) >> 1);
			sel_pix.cr = 8'(({1'b0, last_reg.cr} + {1'b0, buf_pix.cr}) >> 1);
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			last_reg <= '0;
			half_reg <= 1'b0;
		end else if (produce) begin
			half_reg <= ~half_reg;
			if (!half_reg)
				last_reg <= buf_pix;
		end
	end

	// timing generator
	logic [10:0] h_reg, h_len;
	logic [9:0]  line_reg, f_len;
	logic        field_reg, sync_d_reg, sync_p_reg, fld_d_reg, fld_p_reg;
	logic        h_wrap, field_start, slave_hs, slave_fs;

	assign h_len  = std625_reg ? CLKS_625 : CLKS_525;
	assign f_len  = std625_reg ? (field_reg ? FLD1_625 : FLD0_625)
	                           : (field_reg ? FLD1_525 : FLD0_525);
	assign h_wrap = (h_reg == 11'(h_len - 11'd1));

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sync_d_reg <= 1'b1;
			sync_p_reg <= 1'b1;
			fld_d_reg  <= 1'b1;
			fld_p_reg  <= 1'b1;
		end else begin
			sync_d_reg <= I_LINE_SYNC_N;
			sync_p_reg <= sync_d_reg;
			fld_d_reg  <= I_FIELD_VSYNC;
			fld_p_reg  <= fld_d_reg;
		end
	end

	assign slave_hs = ~master_reg & ~sync_d_reg & sync_p_reg;
	always_comb begin
		slave_fs = 1'b0;
		if (!master_reg) begin
			case (tmode_reg)
				TMODE_1: slave_fs = fld_d_reg ^ fld_p_reg;
				TMODE_2: slave_fs = ~fld_d_reg & fld_p_reg;
				default: slave_fs = trc_fchg;
			endcase
		end
	end
	assign field_start = master_reg ? (h_wrap && line_reg == 10'(f_len - 10'd1))
	                                : slave_fs;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			h_reg     <= 11'd0;
			line_reg  <= 10'd0;
			field_reg <= 1'b0;
		end else begin
			if (slave_hs || trc_eav || h_wrap)
				h_reg <= 11'd0;
			else
				h_reg <= 11'(h_reg + 11'd1);
			if (field_start) begin
				line_reg  <= 10'd0;
				field_reg <= master_reg ? ~field_reg
				           : (tmode_reg == TMODE_1 ? fld_d_reg
				           : (tmode_reg == TMODE_2 ? ~field_reg : trc_f_reg));
			end else if (slave_hs || trc_eav || h_wrap) begin
				line_reg <= 10'(line_reg + 10'd1);
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_LINE_SYNC_N  <= 1'b1;
			O_FIELD_VSYNC  <= 1'b0;
		end else begin
			O_LINE_SYNC_N <= ~(h_reg >= I_HSYNC_START &&
			                   h_reg < 11'(I_HSYNC_START + I_HSYNC_WIDTH));
			O_FIELD_VSYNC <= (tmode_reg == TMODE_2)
			               ? ~(line_reg < {6'd0, I_VSYNC_LINES}) : field_reg;
		end
	end
	assign O_LINE_SYNC_OE   = master_reg;
	assign O_FIELD_VSYNC_OE = master_reg & (tmode_reg == TMODE_1 ||
	                                        tmode_reg == TMODE_2);
	assign O_FIELD          = field_reg;

	// subcarrier reset / line lock pin
	logic [1:0]          scsel;
	logic                sc_s1_reg, sc_s2_reg, sc_s3_reg, sc_fall;
	logic                sc_pend_reg, rtc_run_reg, rtc_tick_reg, lock_ok_reg;
	logic [6:0]          rtc_cnt_reg;
	logic [RTC_SC_W-1:0] rtc_word_reg, rtc_inc_reg;

	assign scsel   = {I_SUBCARRIER_PIN_SELECT_HI, I_SUBCARRIER_PIN_SELECT_LO};
	assign sc_fall = ~sc_s2_reg & sc_s3_reg;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sc_s1_reg <= 1'b1;
			sc_s2_reg <= 1'b1;
			sc_s3_reg <= 1'b1;
		end else begin
			sc_s1_reg <= I_SUBCARRIER_RESET_OR_LOCK_IN;
			sc_s2_reg <= sc_s1_reg;
			sc_s3_reg <= sc_s2_reg;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sc_pend_reg <= 1'b0;
		end else if (scsel == SCSEL_RESET && sc_fall) begin
			sc_pend_reg <= 1'b1; // a new edge wins over the clear
		end else if (field_start || scsel != SCSEL_RESET) begin
			sc_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rtc_run_reg  <= 1'b0;
			rtc_tick_reg <= 1'b0;
			rtc_cnt_reg  <= 7'd0;
			rtc_word_reg <= '0;
			rtc_inc_reg  <= '0;
			lock_ok_reg  <= 1'b0;
		end else if (scsel != SCSEL_LOCK) begin
			rtc_run_reg <= 1'b0;
			lock_ok_reg <= 1'b0;
		end else if (!rtc_run_reg) begin
			if (sc_s2_reg) begin // start bit
				rtc_run_reg  <= 1'b1;
				rtc_tick_reg <= 1'b0;
				rtc_cnt_reg  <= 7'd0;
			end
		end else begin // one bit per two clocks
			rtc_tick_reg <= ~rtc_tick_reg;
			if (rtc_tick_reg) begin
				if (rtc_cnt_reg < 7'(RTC_SC_W))
					rtc_word_reg[5'(rtc_cnt_reg)] <= sc_s2_reg;
				if (rtc_cnt_reg == 7'(RTC_BITS - 7'd1)) begin
					rtc_run_reg <= 1'b0;
					rtc_inc_reg <= rtc_word_reg;
					lock_ok_reg <= 1'b1;
				end
				rtc_cnt_reg <= 7'(rtc_cnt_reg + 7'd1);
			end
		end
	end

	// subcarrier synthesiser and modulator
	logic [31:0]       sc_acc_reg, sc_inc, inc_base;
	logic signed [7:0] sin_s, cos_s;
	logic signed [8:0] u_s, v_s;
	logic signed [17:0] c_acc;
	logic signed [9:0] chroma_s;
	logic signed [11:0] comp_sum;

	assign inc_base = std625_reg ? SC_INC_625 : SC_INC_525;
	assign sc_inc   = lock_ok_reg ? {inc_base[31:RTC_SC_W], rtc_inc_reg}
	                              : inc_base;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST)
			sc_acc_reg <= 32'h0000_0000;
		else if (sc_pend_reg && field_start)
			sc_acc_reg <= 32'h0000_0000;
		else
			sc_acc_reg <= 32'(sc_acc_reg + sc_inc);
	end

	assign sin_s    = signed'(vepfe_sine(sc_acc_reg[31:26]));
	assign cos_s    = signed'(vepfe_sine(6'(sc_acc_reg[31:26] + 6'd16)));
	assign u_s      = signed'({1'b0, sel_pix.cb}) - 9'sd128;
	assign v_s      = signed'({1'b0, sel_pix.cr}) - 9'sd128;
	assign c_acc    = 18'(u_s * sin_s) + 18'(v_s * cos_s);
	assign chroma_s = 10'(c_acc >>> 6);
	assign comp_sum = signed'({2'b00, sel_pix.y, 2'b00}) + 12'(chroma_s);

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_OUT_VALID <= 1'b0;
			O_COMPOSITE <= 10'h000;
			O_LUMA      <= 10'h000;
			O_CHROMA    <= 10'h000;
			O_COMPONENT <= '0;
		end else begin
			O_OUT_VALID <= produce;
			if (produce) begin
				if (comp_sum < 0)
					O_COMPOSITE <= 10'h000;
				else if (comp_sum > 12'(COMP_MAX))
					O_COMPOSITE <= COMP_MAX;
				else
					O_COMPOSITE <= comp_sum[9:0];
				O_LUMA      <= comp_reg ? 10'h000 : {sel_pix.y, 2'b00};
				O_CHROMA    <= comp_reg ? 10'h000
				                        : 10'(CHROMA_OFS + chroma_s);
				O_COMPONENT <= sel_pix;
			end
		end
	end

	// host two-wire serial target, write direction
	logic       scl1_reg, scl2_reg, scl3_reg, sda1_reg, sda2_reg, sda3_reg;
	logic       scl_rise, scl_fall, i2c_start, i2c_stop, rd_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg;
	logic [6:0] my_addr;
	vepfe_i2c_e i2c_reg;

	assign my_addr   = {ADDR_BASE, I_TARGET_ADDRESS_SELECT};
	assign scl_rise  = scl2_reg & ~scl3_reg;
	assign scl_fall  = ~scl2_reg & scl3_reg;
	assign i2c_start = scl2_reg & scl3_reg & ~sda2_reg & sda3_reg;
	assign i2c_stop  = scl2_reg & scl3_reg & sda2_reg & ~sda3_reg;
	assign O_HOST_SERIAL_DATA = 1'b0;

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			{scl1_reg, scl2_reg, scl3_reg} <= 3'b111;
			{sda1_reg, sda2_reg, sda3_reg} <= 3'b111;
		end else begin
			{scl1_reg, scl2_reg, scl3_reg} <= {I_HOST_SERIAL_CLOCK,
			                                   scl1_reg, scl2_reg};
			{sda1_reg, sda2_reg, sda3_reg} <= {I_HOST_SERIAL_DATA,
			                                   sda1_reg, sda2_reg};
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			i2c_reg               <= I2C_IDLE;
			bit_reg               <= 4'd0;
			sh_reg                <= 8'h00;
			rd_reg                <= 1'b0;
			O_HOST_SERIAL_DATA_OE <= 1'b0;
			O_HOST_BYTE           <= 8'h00;
			O_HOST_BYTE_VALID     <= 1'b0;
			O_HOST_BYTE_FIRST     <= 1'b0;
		end else begin
			O_HOST_BYTE_VALID <= 1'b0;
			if (i2c_start) begin
				i2c_reg               <= I2C_ADDR;
				bit_reg               <= 4'd0;
				O_HOST_SERIAL_DATA_OE <= 1'b0;
				O_HOST_BYTE_FIRST     <= 1'b1;
			end else if (i2c_stop) begin
				i2c_reg               <= I2C_IDLE;
				O_HOST_SERIAL_DATA_OE <= 1'b0;
			end else begin
				case (i2c_reg)
					I2C_ADDR, I2C_DATA: begin
						if (scl_rise && bit_reg != 4'd8) begin
							sh_reg  <= {sh_reg[6:0], sda2_reg};
							bit_reg <= 4'(bit_reg + 4'd1);
						end else if (scl_fall && bit_reg == 4'd8) begin
							if (i2c_reg == I2C_DATA) begin
								O_HOST_BYTE       <= sh_reg;
								O_HOST_BYTE_VALID <= 1'b1;
								O_HOST_SERIAL_DATA_OE <= 1'b1;
								i2c_reg           <= I2C_ACK;
							end else if (sh_reg[7:1] == my_addr) begin
								rd_reg                <= sh_reg[0];
								O_HOST_SERIAL_DATA_OE <= 1'b1;
								i2c_reg               <= I2C_ACK;
							end else begin
								i2c_reg <= I2C_IGNORE;
							end
						end
					end
					I2C_ACK: begin
						if (scl_fall) begin
							O_HOST_SERIAL_DATA_OE <= 1'b0;
							O_HOST_BYTE_FIRST     <= (bit_reg == 4'd8 &&
							                          sh_reg[7:1] == my_addr &&
							                          O_HOST_BYTE_FIRST &&
							                          !O_HOST_BYTE_VALID &&
							                          !rd_reg);
							bit_reg               <= 4'd0;
							i2c_reg <= rd_reg ? I2C_IGNORE : I2C_DATA;
						end
					end
					default: ;
				endcase
			end
		end
	end
endmodule : vepfe_top

/* vepfe_top_properties.sv */
/* Port assertions of vepfe_top, bound after the module.
   Assumes one clock and the async low reset. */
`timescale 1ns/1ns
module vepfe_top_properties (
	input wire logic        I_CLK,
	input wire logic        I_NRST,
	input wire logic        I_MODE_LOAD,
	input wire logic        I_OUT_READY,
	input wire logic [10:0] I_HSYNC_WIDTH,
	input wire logic        O_LINE_SYNC_N,
	input wire logic        O_LINE_SYNC_OE,
	input wire logic        O_FIELD_VSYNC_OE,
	input wire logic        O_OUT_VALID,
	input wire logic [9:0]  O_LUMA,
	input wire logic        O_MASTER,
	input wire logic        O_STD_625,
	input wire logic        O_WIDE_BUS,
	input wire logic        O_SQUARE_ACTIVE,
	input wire logic        O_HOST_SERIAL_DATA
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	sequence s_low4;
		(!O_LINE_SYNC_N) [*4] ##1 O_LINE_SYNC_N;
	endsequence
	chk_sync_oe: assert property (O_LINE_SYNC_OE == O_MASTER)
		else $error("sync oe");
	chk_field_oe: assert property (O_FIELD_VSYNC_OE |-> O_MASTER)
		else $error("field oe");
	chk_square_slave: assert property (O_SQUARE_ACTIVE |-> !O_MASTER)
		else $error("square");
	chk_stall_quiet: assert property (!I_OUT_READY |=> !O_OUT_VALID)
		else $error("stall");
	chk_data_hold: assert property ($changed(O_LUMA) |-> O_OUT_VALID)
		else $error("hold");
	chk_mode_latch: assert property (
		$changed({O_MASTER, O_STD_625, O_WIDE_BUS}) |-> $past(I_MODE_LOAD))
		else $error("mode");
	chk_sync_width: assert property (
		$fell(O_LINE_SYNC_N) && I_HSYNC_WIDTH == 11'h004 |-> s_low4)
		else $error("width");
	chk_ack_low: assert property (O_HOST_SERIAL_DATA == 1'b0)
		else $error("sda");
endmodule : vepfe_top_properties

bind vepfe_top vepfe_top_properties u_chk (.*);

/* vepfe_src_model.sv */
/* Upstream pixel source model.
   Assumes the bench clock; drives on falling edges. */
`timescale 1ns/1ns
module vepfe_src_model (
	input  wire logic   i_clk,
	input  wire logic   i_run,
	input  wire logic   i_wide,
	output logic [15:0] o_bus,
	output logic        o_blank_n
);
	logic [2:0] k;
	logic [7:0] b;
	// timing code, then Cb Y Cr Y in range
	assign b = k == 3'h0 ? 8'hff : k < 3'h4 ? 8'h00 : k[0] ? 8'h40 : 8'h80;
	initial {k, o_bus, o_blank_n} = 20'h00000;
	always @(negedge i_clk) begin
		o_blank_n <= i_run;
		k <= !i_run ? 3'h0 : k == 3'h5 ? 3'h4 : k + 3'h1;
		// ignored bus and narrow top byte carry garbage
		o_bus <= !i_run ? ~o_bus : i_wide ? 16'h8040 : {~b, b};
	end
endmodule : vepfe_src_model

/* vepfe_top_bench.sv */
/* Bench of vepfe_top with source model and bound checker.
   Assumes design and checker files compile first. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
	mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
module vepfe_top_bench;
	import vepfe_pkg::*;
	logic        I_CLK = 1'b0, I_NRST = 1'b0, I_MODE_LOAD = 1'b0, run = 1'b0;
	logic        I_OUT_READY = 1'b1, I_SUBCARRIER_RESET_OR_LOCK_IN = 1'b1;
	logic [10:0] I_HSYNC_START = 11'h010, I_HSYNC_WIDTH = 11'h004;
	logic [3:0]  I_VSYNC_LINES = 4'h3;
	logic [6:0]  m = 7'h00;
	logic [1:0]  sel = 2'h0;
	wire  [15:0] I_PIXEL_BUS;
	wire  [1:0]  I_TIMING_MODE;
	wire         I_BLANK_N, I_LINE_SYNC_N, I_FIELD_VSYNC, I_STD_625, I_MASTER;
	wire         I_WIDE_BUS, I_SQUARE_PIXEL, I_COMPONENT_OUT;
	wire         I_SUBCARRIER_PIN_SELECT_HI, I_SUBCARRIER_PIN_SELECT_LO;
	logic        I_TARGET_ADDRESS_SELECT = 1'b1, I_HOST_SERIAL_CLOCK = 1'b1;
	logic        sda = 1'b1;
	wire         I_HOST_SERIAL_DATA, O_LINE_SYNC_N, O_LINE_SYNC_OE;
	wire         O_FIELD_VSYNC, O_FIELD_VSYNC_OE, O_PIXEL_READY, O_OUT_VALID;
	wire         O_FIELD, O_STD_625, O_MASTER, O_WIDE_BUS, O_SQUARE_ACTIVE;
	wire         O_HOST_SERIAL_DATA, O_HOST_SERIAL_DATA_OE;
	wire         O_HOST_BYTE_VALID, O_HOST_BYTE_FIRST;
	wire  [9:0]  O_COMPOSITE, O_LUMA, O_CHROMA;
	wire  [7:0]  O_HOST_BYTE;
	vepfe_pix_s  O_COMPONENT;
	int          mismatches = 0, check_count = 0, cyc = 0;
	assign {I_STD_625, I_MASTER, I_TIMING_MODE, I_WIDE_BUS, I_SQUARE_PIXEL,
		I_COMPONENT_OUT} = m;
	assign {I_SUBCARRIER_PIN_SELECT_HI, I_SUBCARRIER_PIN_SELECT_LO} = sel;
	// shared pins pulled up when undriven
	assign I_LINE_SYNC_N = O_LINE_SYNC_OE ? O_LINE_SYNC_N : 1'b1;
	assign I_FIELD_VSYNC = O_FIELD_VSYNC_OE ? O_FIELD_VSYNC : 1'b1;
	assign I_HOST_SERIAL_DATA = sda & !O_HOST_SERIAL_DATA_OE;
	always #50 I_CLK = ~I_CLK;
	vepfe_top dut (.*);
	vepfe_src_model src (.i_clk(I_CLK), .i_run(run), .i_wide(m[2]),
		.o_bus(I_PIXEL_BUS), .o_blank_n(I_BLANK_N));
	task automatic complete_run;
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	task automatic tick(input int n);
		repeat (n) @(negedge I_CLK);
	endtask : tick
	task automatic load(input logic [6:0] v);
		tick(1);
		m = v;
		I_MODE_LOAD = 1'b1;
		tick(1);
		I_MODE_LOAD = 1'b0;
	endtask : load
	task automatic outs(input logic [29:0] e);
		logic [29:0] got;
		repeat (6) begin
			tick(1);
			for (int n = 0; n < 40 && O_OUT_VALID !== 1'b1; n++) tick(1);
			got = m[0] ? {O_COMPOSITE, O_COMPONENT[19:0]} :
				{O_COMPOSITE, O_LUMA, O_CHROMA};
			`CHK("out", e, got)
		end
	endtask : outs
	task automatic t_narrow;
		load(7'h00);
		run = 1'b1;
		tick(30);
		I_OUT_READY = 1'b0;
		tick(12);
		`CHK("full", 1'b0, O_PIXEL_READY)
		I_OUT_READY = 1'b1;
		outs({10'h100, 10'h100, 10'h200});
	endtask : t_narrow
	task automatic t_wide;
		load(7'h05);
		tick(30);
		`CHK("wide", 1'b1, O_WIDE_BUS)
		outs({10'h100, 20'h08080});
	endtask : t_wide
	task automatic t_blank;
		logic [7:0] cnt;
		cnt = 8'h00;
		run = 1'b0;
		tick(12);
		repeat (20) begin
			tick(1);
			cnt += {7'h00, O_OUT_VALID};
		end
		`CHK("blank", 8'h00, cnt)
	endtask : t_blank
	task automatic t_sync;
		logic [11:0] low;
		logic [3:0]  g;
		low = 12'h000;
		load(7'h02);
		`CHK("square", 1'b1, O_SQUARE_ACTIVE)
		for (int t = 1; t < 3; t++) begin
			load({t[1], 1'b1, t[1:0], 3'h2});
			g = {O_STD_625, O_SQUARE_ACTIVE, O_LINE_SYNC_OE, O_FIELD_VSYNC_OE};
			`CHK("oe", {t[1], 3'h3}, g)
		end
		sel = 2'h1;
		I_SUBCARRIER_RESET_OR_LOCK_IN = 1'b0;
		tick(4);
		repeat (CLKS_625) begin
			tick(1);
			low += {11'h000, !O_LINE_SYNC_N};
		end
		`CHK("hsync", 12'h004, low)
	endtask : t_sync
	task automatic t_host(input logic a, input logic s);
		logic [17:0] f;
		logic [4:0]  ack;
		// address, write, ack slot, data byte, ack slot
		f = {ADDR_BASE, a, 1'b0, 1'b1, 8'h5a, 1'b1};
		ack = 5'h00;
		I_TARGET_ADDRESS_SELECT = s;
		sda = 1'b0;
		tick(8);
		for (int i = 17; i >= 0; i--) begin
			I_HOST_SERIAL_CLOCK = 1'b0;
			tick(4);
			sda = f[i];
			tick(4);
			I_HOST_SERIAL_CLOCK = 1'b1;
			tick(4);
			ack += {4'h0, f[i] & !I_HOST_SERIAL_DATA};
		end
		`CHK("ack", (a == s) ? 5'h02 : 5'h00, ack)
		`CHK("byte", 8'h5a, O_HOST_BYTE)
		`CHK("first", 1'b1, O_HOST_BYTE_FIRST)
		I_HOST_SERIAL_CLOCK = 1'b0;
		tick(4);
		sda = 1'b0;
		tick(4);
		I_HOST_SERIAL_CLOCK = 1'b1;
		tick(4);
		sda = 1'b1;
		tick(4);
	endtask : t_host
	initial begin
		tick(6);
		I_NRST = 1'b1;
		`CHK("dflt", 4'h0, {O_STD_625,O_MASTER,O_WIDE_BUS,O_LINE_SYNC_OE})
		t_narrow();
		t_wide();
		t_blank();
		t_sync();
		t_host(1'b1, 1'b1);
		t_host(1'b0, 1'b1);
		complete_run();
	end
	always @(posedge I_CLK) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			complete_run();
		end
	end
endmodule : vepfe_top_bench
